// [pkg/charge_time_pkg.sv]
// Shared constants and types for the charge-time edge control block.
package charge_time_pkg;

    // Bus geometry.
    localparam int          AXI_ADDR_W     = 8;
    localparam int          AXI_DATA_W     = 32;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;

    // Register byte offsets.
    localparam logic [7:0]  OFF_TRIM_RANGE = 8'h00;
    localparam logic [7:0]  OFF_EDGE_CTRL  = 8'h04;
    localparam logic [7:0]  OFF_UNIT_CTRL  = 8'h08;
    localparam logic [7:0]  OFF_IRQ_STATUS = 8'h0C;
    localparam logic [7:0]  OFF_IRQ_MASK   = 8'h10;
    localparam logic [7:0]  OFF_LIVE_STATE = 8'h14;

    // Current source trim and range register fields.
    localparam int          RANGE_LSB      = 0;
    localparam int          TRIM_LSB       = 2;
    localparam logic [1:0]  RANGE_LOWEST   = 2'h1;
    localparam logic [5:0]  TRIM_NEUTRAL   = 6'h00;
    localparam logic [5:0]  TRIM_MAX_NEG   = 6'h21;
    localparam logic [5:0]  TRIM_MAX_POS   = 6'h1F;

    // Edge channel control register fields.
    localparam int          SEEN1_BIT      = 0;
    localparam int          SEEN2_BIT      = 1;
    localparam int          SEL1_LSB       = 2;
    localparam int          POL1_BIT       = 4;
    localparam int          SEL2_LSB       = 5;
    localparam int          POL2_BIT       = 7;

    // Unit control and live state fields.
    localparam int          ORDER_BIT      = 2;
    localparam int          LIVE_ON_BIT    = 0;
    localparam int          LIVE_CH1_BIT   = 1;
    localparam int          LIVE_CH2_BIT   = 2;

    // Reset values.
    localparam logic [1:0]  RANGE_RST      = 2'h0;
    localparam logic        ORDER_RST      = 1'h0;
    localparam logic [1:0]  MASK_RST       = 2'h0;

    // Source codes of an edge channel.
    typedef enum logic [1:0] {
        SRC_PIN_ONE,
        SRC_PIN_TWO,
        SRC_CAP_ONE,
        SRC_CAP_TWO
    } edge_source_t;

    // All candidate sources of an edge channel, in the clock domain.
    typedef struct packed {
        logic pin_one;
        logic pin_two;
        logic cap_one;
        logic cap_two;
    } edge_inputs_t;

    // Setup of one edge channel.
    typedef struct packed {
        edge_source_t source;
        logic         polarity;
    } edge_cfg_t;

    localparam edge_cfg_t   CFG_RST        = '{source: SRC_PIN_ONE, polarity: 1'h0};

endpackage

// [design/edge_sync.sv]
// Two-stage synchroniser for the two edge input pins.
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // Pin levels and their synchronised copies
    input  wire logic [1:0] async_in,
    output logic      [1:0] sync_out
);

    logic [1:0] first_stage;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            first_stage <= 2'h0;
            sync_out    <= 2'h0;
        end else begin
            first_stage <= async_in;
            sync_out    <= first_stage;
        end
    end

endmodule
`default_nettype wire

// [design/edge_channel.sv]
// Source selection and polarity adjustment of one edge channel.
`timescale 1ns/1ps
`default_nettype none
module edge_channel (
    // Candidate sources, already in the clock domain
    input  wire charge_time_pkg::edge_inputs_t sources,
    // Channel setup
    input  wire charge_time_pkg::edge_cfg_t    cfg,
    // High while the chosen source stands at the responding level
    output logic                               active
);

    function automatic logic pick_source(input charge_time_pkg::edge_inputs_t src,
                                         input charge_time_pkg::edge_source_t sel);
        logic level;
        level = 1'b0;
        case (sel)
            charge_time_pkg::SRC_PIN_ONE: level = src.pin_one;
            charge_time_pkg::SRC_PIN_TWO: level = src.pin_two;
            charge_time_pkg::SRC_CAP_ONE: level = src.cap_one;
            charge_time_pkg::SRC_CAP_TWO: level = src.cap_two;
            default:                      level = 1'b0;
        endcase
        return level;
    endfunction

    // The present level is compared, so no transition is needed to respond.
    assign active = (pick_source(sources, cfg.source) == cfg.polarity);

endmodule
`default_nettype wire

// [design/charge_time_edge_control.sv]
// Edge channels, status bits, current source gating and AXI4-Lite registers.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Two-bit current range field drives the current source; code 01 is lowest.
// - Six-bit signed trim field: 000000 neutral, 100001 most negative, 011111 most positive.
// - Each channel picks one of two edge pins or two capture triggers.
// - Channels respond to the present adjusted level, not to a transition.
// - Each channel has its own polarity bit: bit 7 channel two, bit 4 channel one.
// - With ordering enabled, channel two is ignored until channel one has responded.
// - A response sets the channel's seen bit, which stays set until cleared.
// - Reconfiguring a channel to match its present level sets its seen bit at once.
// - Current source is on only while exactly one seen bit is set.
// - Software may write the seen bits directly, turning the source on or off.
module charge_time_edge_control (
    // Clock and reset
    input  wire logic                                     clock,
    input  wire logic                                     sys_rst,
    // AXI4-Lite write address
    input  wire logic [charge_time_pkg::AXI_ADDR_W-1:0]   awaddr,
    input  wire logic                                     awvalid,
    output logic                                          awready,
    // AXI4-Lite write data
    input  wire logic [charge_time_pkg::AXI_DATA_W-1:0]   wdata,
    input  wire logic [3:0]                               wstrb,
    input  wire logic                                     wvalid,
    output logic                                          wready,
    // AXI4-Lite write response
    output logic [1:0]                                    bresp,
    output logic                                          bvalid,
    input  wire logic                                     bready,
    // AXI4-Lite read address
    input  wire logic [charge_time_pkg::AXI_ADDR_W-1:0]   araddr,
    input  wire logic                                     arvalid,
    output logic                                          arready,
    // AXI4-Lite read data
    output logic [charge_time_pkg::AXI_DATA_W-1:0]        rdata,
    output logic [1:0]                                    rresp,
    output logic                                          rvalid,
    input  wire logic                                     rready,
    // Edge sources
    input  wire logic                                     edge_pin_one,
    input  wire logic                                     edge_pin_two,
    input  wire logic                                     capture_unit_one_trigger,
    input  wire logic                                     capture_unit_two_trigger,
    // Analog current source control
    output logic                                          current_source_on,
    output logic [1:0]                                    current_range_sel,
    output logic [5:0]                                    current_trim,
    // Interrupt
    output logic                                          irq
);

    typedef enum {wr_collect, wr_respond} write_state_t;
    typedef enum {rd_idle, rd_respond} read_state_t;

    write_state_t                   wr_state;
    read_state_t                    rd_state;
    logic [7:0]                     aw_addr_q;
    logic [7:0]                     w_data_q;
    logic                           w_strb_q;
    logic [1:0]                     pins_sync;
    charge_time_pkg::edge_inputs_t  sources;
    charge_time_pkg::edge_cfg_t     chan1_cfg;
    charge_time_pkg::edge_cfg_t     chan2_cfg;
    logic                           chan1_active;
    logic                           chan2_active;
    logic                           chan2_hit;
    logic                           chan1_seen;
    logic                           chan2_seen;
    logic                           next_chan1_seen;
    logic                           next_chan2_seen;
    logic                           edge_order_enable;
    logic [1:0]                     irq_status;
    logic [1:0]                     irq_mask;
    logic [1:0]                     next_irq_status;
    logic [1:0]                     next_irq_mask;
    logic                           aw_have;
    logic                           w_have;
    logic                           wr_fire;
    logic [7:0]                     wr_addr;
    logic [7:0]                     wr_data;
    logic                           wr_strb;
    logic                           reg_wr;
    logic                           edge_wr;
    logic [7:0]                     rd_word;

    function automatic logic addr_known(input logic [7:0] a);
        return (a == charge_time_pkg::OFF_TRIM_RANGE) || (a == charge_time_pkg::OFF_EDGE_CTRL)
            || (a == charge_time_pkg::OFF_UNIT_CTRL)  || (a == charge_time_pkg::OFF_IRQ_STATUS)
            || (a == charge_time_pkg::OFF_IRQ_MASK)   || (a == charge_time_pkg::OFF_LIVE_STATE);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Edge sources and channels.

    edge_sync u_pin_sync (
        .clock    (clock),
        .sys_rst  (sys_rst),
        .async_in ({edge_pin_two, edge_pin_one}),
        .sync_out (pins_sync)
    );

    assign sources = '{pin_one: pins_sync[0], pin_two: pins_sync[1],
                       cap_one: capture_unit_one_trigger, cap_two: capture_unit_two_trigger};

    edge_channel u_chan1 (
        .sources (sources),
        .cfg     (chan1_cfg),
        .active  (chan1_active)
    );

    edge_channel u_chan2 (
        .sources (sources),
        .cfg     (chan2_cfg),
        .active  (chan2_active)
    );

    // With ordering enabled, channel two only counts once channel one was seen in an earlier cycle.
    assign chan2_hit = chan2_active && (!edge_order_enable || chan1_seen);

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Write channel: address and data are taken in either order, then answered.

    assign aw_have = !awready || awvalid;
    assign w_have  = !wready || wvalid;
    assign wr_fire = (wr_state == wr_collect) && aw_have && w_have;
    assign wr_addr = awready ? awaddr : aw_addr_q;
    assign wr_data = wready ? wdata[7:0] : w_data_q;
    assign wr_strb = wready ? wstrb[0] : w_strb_q;
    assign reg_wr  = wr_fire && wr_strb && addr_known(wr_addr);
    assign edge_wr = reg_wr && (wr_addr == charge_time_pkg::OFF_EDGE_CTRL);

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wr_state  <= wr_collect;
            awready   <= 1'b1;
            wready    <= 1'b1;
            bvalid    <= 1'b0;
            bresp     <= charge_time_pkg::RESP_OKAY;
            aw_addr_q <= 8'h00;
            w_data_q  <= 8'h00;
            w_strb_q  <= 1'b0;
        end else begin
            case (wr_state)
                wr_collect: begin
                    if (awready && awvalid) begin
                        aw_addr_q <= awaddr;
                        awready   <= 1'b0;
                    end
                    if (wready && wvalid) begin
                        w_data_q <= wdata[7:0];
                        w_strb_q <= wstrb[0];
                        wready   <= 1'b0;
                    end
                    if (wr_fire) begin
                        awready  <= 1'b0;
                        wready   <= 1'b0;
                        bvalid   <= 1'b1;
                        bresp    <= addr_known(wr_addr) ? charge_time_pkg::RESP_OKAY
                                                        : charge_time_pkg::RESP_SLVERR;
                        wr_state <= wr_respond;
                    end
                end
                wr_respond: begin
                    if (bready) begin
                        bvalid   <= 1'b0;
                        awready  <= 1'b1;
                        wready   <= 1'b1;
                        wr_state <= wr_collect;
                    end
                end
                default: wr_state <= wr_collect;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Configuration registers.

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            current_range_sel <= charge_time_pkg::RANGE_RST;
            current_trim      <= charge_time_pkg::TRIM_NEUTRAL;
        end else if (reg_wr && (wr_addr == charge_time_pkg::OFF_TRIM_RANGE)) begin
            current_range_sel <= wr_data[charge_time_pkg::RANGE_LSB +: 2];
            current_trim      <= wr_data[charge_time_pkg::TRIM_LSB +: 6];
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            chan1_cfg <= charge_time_pkg::CFG_RST;
            chan2_cfg <= charge_time_pkg::CFG_RST;
        end else if (edge_wr) begin
            chan1_cfg.source   <= charge_time_pkg::edge_source_t'(wr_data[charge_time_pkg::SEL1_LSB +: 2]);
            chan1_cfg.polarity <= wr_data[charge_time_pkg::POL1_BIT];
            chan2_cfg.source   <= charge_time_pkg::edge_source_t'(wr_data[charge_time_pkg::SEL2_LSB +: 2]);
            chan2_cfg.polarity <= wr_data[charge_time_pkg::POL2_BIT];
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            edge_order_enable <= charge_time_pkg::ORDER_RST;
        end else if (reg_wr && (wr_addr == charge_time_pkg::OFF_UNIT_CTRL)) begin
            edge_order_enable <= wr_data[charge_time_pkg::ORDER_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Seen bits and current source gate. A response in the cycle of a software
    // write wins, so a still-active channel re-sets its bit right away.

    always_comb begin
        next_chan1_seen = chan1_active
                          || (edge_wr ? wr_data[charge_time_pkg::SEEN1_BIT] : chan1_seen);
        next_chan2_seen = chan2_hit
                          || (edge_wr ? wr_data[charge_time_pkg::SEEN2_BIT] : chan2_seen);
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            chan1_seen        <= 1'b0;
            chan2_seen        <= 1'b0;
            current_source_on <= 1'b0;
        end else begin
            chan1_seen        <= next_chan1_seen;
            chan2_seen        <= next_chan2_seen;
            current_source_on <= next_chan1_seen ^ next_chan2_seen;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Interrupts: a hardware response that newly sets a seen bit is an event.

    always_comb begin
        next_irq_mask = irq_mask;
        if (reg_wr && (wr_addr == charge_time_pkg::OFF_IRQ_MASK)) begin
            next_irq_mask = wr_data[1:0];
        end
        next_irq_status = irq_status;
        if (reg_wr && (wr_addr == charge_time_pkg::OFF_IRQ_STATUS)) begin
            next_irq_status = irq_status & ~wr_data[1:0];
        end
        next_irq_status = next_irq_status | {chan2_hit && !chan2_seen, chan1_active && !chan1_seen};
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            irq_status <= 2'h0;
            irq_mask   <= charge_time_pkg::MASK_RST;
            irq        <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            irq_mask   <= next_irq_mask;
            irq        <= |(next_irq_status & next_irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Read channel.

    always_comb begin
        rd_word = 8'h00;
        case (araddr)
            charge_time_pkg::OFF_TRIM_RANGE: rd_word = {current_trim, current_range_sel};
            charge_time_pkg::OFF_EDGE_CTRL:  rd_word = {chan2_cfg.polarity, chan2_cfg.source, chan1_cfg.polarity,
                                                        chan1_cfg.source, chan2_seen, chan1_seen};
            charge_time_pkg::OFF_UNIT_CTRL:  rd_word = {5'h00, edge_order_enable, 2'h0};
            charge_time_pkg::OFF_IRQ_STATUS: rd_word = {6'h00, irq_status};
            charge_time_pkg::OFF_IRQ_MASK:   rd_word = {6'h00, irq_mask};
            charge_time_pkg::OFF_LIVE_STATE: rd_word = {5'h00, chan2_active, chan1_active, current_source_on};
            default:                         rd_word = 8'h00;
        endcase
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rd_state <= rd_idle;
            arready  <= 1'b1;
            rvalid   <= 1'b0;
            rresp    <= charge_time_pkg::RESP_OKAY;
            rdata    <= 32'h0000_0000;
        end else begin
            case (rd_state)
                rd_idle: begin
                    if (arvalid) begin
                        arready  <= 1'b0;
                        rvalid   <= 1'b1;
                        rdata    <= {24'h00_0000, rd_word};
                        rresp    <= addr_known(araddr) ? charge_time_pkg::RESP_OKAY
                                                       : charge_time_pkg::RESP_SLVERR;
                        rd_state <= rd_respond;
                    end
                end
                rd_respond: begin
                    if (rready) begin
                        rvalid   <= 1'b0;
                        arready  <= 1'b1;
                        rd_state <= rd_idle;
                    end
                end
                default: rd_state <= rd_idle;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence pin1_armed_s;
        (pins_sync[0] == 1'b0) ##1 (edge_pin_one && (chan1_cfg.source == charge_time_pkg::SRC_PIN_ONE)
                                    && chan1_cfg.polarity && !edge_wr)[*3];
    endsequence

    sequence chan2_blocked_s;
        edge_order_enable && !chan1_seen && !chan2_seen && !edge_wr;
    endsequence

    range_write_a: assert property (reg_wr && (wr_addr == charge_time_pkg::OFF_TRIM_RANGE)
        |=> current_range_sel == $past(wr_data[1:0]))
        else $error("Current range field did not take the written value.");

    trim_write_a: assert property (reg_wr && (wr_addr == charge_time_pkg::OFF_TRIM_RANGE)
        |=> current_trim == $past(wr_data[7:2]))
        else $error("Current trim field did not take the written value.");

    pin_sync_a: assert property (pin1_armed_s |=> chan1_seen)
        else $error("Held edge pin level did not set channel one after synchronising.");

    level_sets_a: assert property (chan1_active |=> chan1_seen)
        else $error("Active channel one level did not set its seen bit.");

    seen_sticky_a: assert property (chan2_seen && !edge_wr |=> chan2_seen)
        else $error("Channel two seen bit cleared without a write.");

    order_block_a: assert property (chan2_blocked_s |=> !chan2_seen)
        else $error("Channel two responded before channel one with ordering on.");

    order_pass_a: assert property (chan2_active && chan1_seen |=> chan2_seen)
        else $error("Channel two response lost after channel one was seen.");

    cfg_match_a: assert property (edge_wr ##1 chan1_active |=> chan1_seen)
        else $error("Matching reconfiguration did not set channel one seen bit.");

    gate_both_a: assert property (chan1_seen && chan2_seen |-> !current_source_on)
        else $error("Current source on while both seen bits are set.");

    gate_one_a: assert property (chan1_seen != chan2_seen |-> current_source_on)
        else $error("Current source off while exactly one seen bit is set.");

    sw_write_a: assert property (edge_wr && !chan1_active && !chan2_active
        |=> {chan2_seen, chan1_seen} == $past(wr_data[1:0]))
        else $error("Written seen bits were not stored.");

    resp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("Write response dropped before it was taken.");

endmodule
`default_nettype wire

// [verification/analog_model.sv]
// Behavioural model of the analog current source.
`timescale 1ns/1ps
`default_nettype none
module analog_model (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        sys_rst,
    // Current source control
    input  wire logic        source_on,
    output logic      [15:0] charge
);
    // Charge grows one unit per cycle of applied current.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            charge <= 16'h0000;
        end else if (source_on) begin
            charge <= charge + 16'h0001;
        end
    end
endmodule
`default_nettype wire

// [verification/tb.sv]
// Register-level testbench of the charge-time edge control block.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0]  wstrb = 4'hF, src = 4'h0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid, current_source_on, irq;
    logic [1:0]  bresp, rresp, resp, current_range_sel;
    logic [5:0]  current_trim;
    logic [15:0] charge;
    int          bad_count = 0, num_checks = 0;
    always #20 clock = ~clock;
    charge_time_edge_control DUT (.clock, .sys_rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .edge_pin_one(src[0]), .edge_pin_two(src[1]), .capture_unit_one_trigger(src[2]),
        .capture_unit_two_trigger(src[3]), .current_source_on, .current_range_sel, .current_trim, .irq);
    analog_model partner (.clock, .sys_rst, .source_on(current_source_on), .charge);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            #1;
        end while (awvalid || wvalid);
        while (bvalid !== 1'b1) @(posedge clock);
        @(posedge clock);
        resp = bresp;
    endtask
    task automatic rr(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clock); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clock); while (rvalid !== 1'b1);
        rd = rdata;
        resp = rresp;
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        rr(8'h04);
        chk(rd, 32'h3);
        wr(8'h00, 32'h85);
        chk(resp, charge_time_pkg::RESP_OKAY);
        chk({current_trim, current_range_sel}, 32'h85);
        rr(8'h00);
        chk(rd, 32'h85);
        wr(8'h10, 32'h3);
        wr(8'h04, 32'hF0);
        // The reset setup still responds to the low pins during the first write, so clear once more.
        wr(8'h04, 32'hF0);
        wr(8'h0C, 32'h3);
        chk(irq, 1'b0);
        src <= 4'h1;
        repeat (5) @(posedge clock);
        chk(current_source_on, 1'b1);
        chk(irq, 1'b1);
        src <= 4'h9;
        repeat (3) @(posedge clock);
        chk(current_source_on, 1'b0);
        chk(charge != 16'h0, 1'b1);
        src <= 4'h0;
        repeat (5) @(posedge clock);
        rr(8'h04);
        chk(rd, 32'hF3);
        wr(8'h04, 32'hF0);
        rr(8'h04);
        chk(rd, 32'hF0);
        wr(8'h0C, 32'h3);
        chk(irq, 1'b0);
        $display("test edges done");
        wr(8'h08, 32'h4);
        src <= 4'h8;
        repeat (5) @(posedge clock);
        rr(8'h04);
        chk(rd, 32'hF0);
        src <= 4'h9;
        repeat (5) @(posedge clock);
        rr(8'h04);
        chk(rd, 32'hF3);
        src <= 4'h0;
        wr(8'h08, 32'h0);
        repeat (4) @(posedge clock);
        wr(8'h04, 32'hE0);
        rr(8'h04);
        chk(rd, 32'hE1);
        chk(current_source_on, 1'b1);
        wr(8'h04, 32'hF0);
        wr(8'h04, 32'hF2);
        chk(current_source_on, 1'b1);
        wr(8'h04, 32'hF3);
        chk(current_source_on, 1'b0);
        $display("test order and software done");
        for (int s = 0; s < 4; s++) begin
            wr(8'h04, 32'hF0 | (s << 2));
            src <= 4'h1 << s;
            repeat (5) @(posedge clock);
            rr(8'h04);
            chk(rd[0], 1'b1);
            src <= 4'h0;
            repeat (4) @(posedge clock);
        end
        rr(8'h20);
        chk(resp, charge_time_pkg::RESP_SLVERR);
        chk(rd, 32'h0);
        $display("test sources and map done");
        print_verdict();
    end
    initial begin
        #200us;
        bad_count++;
        print_verdict();
    end
endmodule
`default_nettype wire
